/* File: logic/sbtc_top.sv */
// Bank-2 configuration registers with decimator, duty-cycle, sync and wake logic
`include "sbtc_regs.svh"

module sbtc_top
    import sbtc_pkg::*;
#(
    parameter int TON_1X_CYC  = `SBTC_TON_1X_US * 1000 / `SBTC_CLK_PERIOD_NS,
    parameter int TON_4X_CYC  = `SBTC_TON_4X_US * 1000 / `SBTC_CLK_PERIOD_NS,
    parameter int TON_8X_CYC  = `SBTC_TON_8X_US * 1000 / `SBTC_CLK_PERIOD_NS,
    parameter int TON_16X_CYC = `SBTC_TON_16X_US * 1000 / `SBTC_CLK_PERIOD_NS,
    parameter int TON_32X_CYC = `SBTC_TON_32X_US * 1000 / `SBTC_CLK_PERIOD_NS
) (
    input  wire logic        sys_clk_in,               // Core clock, 100 MHz
    input  wire logic        rst_in,                   // Asynchronous reset, high
    input  wire sbtc_req_s   req_in,                   // Host register access
    input  wire logic [1:0]  bank_in,                  // Selected user bank
    input  wire logic        accel_filter_choice_in,   // Accel filter enable
    input  wire logic [2:0]  accel_lowpass_setting_in, // Accel filter setting
    input  wire logic        low_power_in,             // Accel low-power mode
    input  wire logic        odr_tick_in,              // Output data rate tick
    input  wire logic        frame_sync_input_in,      // Frame-sync pin
    input  wire logic        sync_polarity_select_in,  // 1: sync active low
    output logic [7:0]       rdata_out,                // Read data
    output sbtc_decim_s      decim_out,                // Self-test and averaging
    output logic [5:0]       avg_count_out,            // Samples averaged
    output logic             accel_on_out,             // Accel powered
    output logic             accel_filter_bypass_out,  // Accel filter bypassed
    output logic             wake_out,                 // Wake-on-sync request
    output logic [15:0]      delay_count_out,          // Sync to tick delay
    output logic             delay_valid_out,          // Delay result pulse
    output logic [6:0]       tag_select_out,           // One-hot low byte slot
    output logic             tag_value_out,            // Sampled sync state
    output logic [2:0]       temperature_filter_out,   // Temp filter setting
    output logic             temp_bypass_out,          // Temp filter bypassed
    output logic             coproc_lp_enable_out      // Coprocessor allowed
);

    ////////////////////////////////////////////////////////////////////////////
    // Register file

    logic [7:0] decim_reg, decim_next;
    logic [7:0] sync_reg, sync_next;
    logic [7:0] temp_reg, temp_next;
    logic [7:0] modctl_reg, modctl_next;
    logic [7:0] rdata_reg, rdata_next;
    logic       in_bank;

    always_comb begin
        in_bank     = (bank_in == `SBTC_BANK_USER2);
        decim_next  = decim_reg;
        sync_next   = sync_reg;
        temp_next   = temp_reg;
        modctl_next = modctl_reg;
        rdata_next  = rdata_reg;
        if (req_in.wr && in_bank) begin
            if (req_in.addr == `SBTC_ADDR_DECIM) begin
                decim_next = req_in.wdata & `SBTC_MASK_DECIM;
            end else if (req_in.addr == `SBTC_ADDR_SYNC) begin
                sync_next = req_in.wdata & `SBTC_MASK_SYNC;
            end else if (req_in.addr == `SBTC_ADDR_TEMP) begin
                temp_next = req_in.wdata & `SBTC_MASK_TEMP;
            end else if (req_in.addr == `SBTC_ADDR_MODCTL) begin
                modctl_next = (req_in.wdata & `SBTC_MASK_MODCTL) | `SBTC_FIXED_MODCTL;
            end
        end
        if (req_in.rd) begin
            rdata_next = 8'h00;
            if (!in_bank) begin
                rdata_next = 8'h00;
            end else if (req_in.addr == `SBTC_ADDR_DECIM) begin
                rdata_next = decim_reg;
            end else if (req_in.addr == `SBTC_ADDR_SYNC) begin
                rdata_next = sync_reg;
            end else if (req_in.addr == `SBTC_ADDR_TEMP) begin
                rdata_next = temp_reg;
            end else if (req_in.addr == `SBTC_ADDR_MODCTL) begin
                rdata_next = modctl_reg;
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            decim_reg  <= `SBTC_RST_DECIM;
            sync_reg   <= `SBTC_RST_SYNC;
            temp_reg   <= `SBTC_RST_TEMP;
            modctl_reg <= `SBTC_RST_MODCTL;
            rdata_reg  <= 8'h00;
        end else begin
            decim_reg  <= decim_next;
            sync_reg   <= sync_next;
            temp_reg   <= temp_next;
            modctl_reg <= modctl_next;
            rdata_reg  <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decimator, filter and coprocessor settings

    sbtc_decim_s decim_o_reg, decim_o_next;
    logic [5:0]  avg_reg, avg_next;
    logic        fbyp_reg, fbyp_next;
    logic [2:0]  tfilt_reg, tfilt_next;
    logic        tbyp_reg, tbyp_next;
    logic        cop_reg, cop_next;

    always_comb begin
        decim_o_next.self_x  = decim_reg[`SBTC_ST_X_BIT];
        decim_o_next.self_y  = decim_reg[`SBTC_ST_Y_BIT];
        decim_o_next.self_z  = decim_reg[`SBTC_ST_Z_BIT];
        decim_o_next.avg_sel = decim_reg[1:0];
        case (decim_reg[1:0])
            2'h1:    avg_next = 6'h08;
            2'h2:    avg_next = 6'h10;
            2'h3:    avg_next = 6'h20;
            default: begin
                // Filter on with any other setting leaves averaging at one
                if (accel_filter_choice_in &&
                    accel_lowpass_setting_in == `SBTC_LPF_AVG4_SET) begin
                    avg_next = 6'h04;
                end else begin
                    avg_next = 6'h01;
                end
            end
        endcase
        fbyp_next  = ~accel_filter_choice_in;
        tfilt_next = temp_reg[2:0];
        tbyp_next  = (temp_reg[2:0] == `SBTC_TEMP_BYPASS_A) ||
                     (temp_reg[2:0] == `SBTC_TEMP_BYPASS_B);
        cop_next   = modctl_reg[`SBTC_LP_COPROC_BIT];
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            decim_o_reg <= '0;
            avg_reg     <= 6'h01;
            fbyp_reg    <= 1'b1;
            tfilt_reg   <= 3'h0;
            tbyp_reg    <= 1'b1;
            cop_reg     <= 1'b1;
        end else begin
            decim_o_reg <= decim_o_next;
            avg_reg     <= avg_next;
            fbyp_reg    <= fbyp_next;
            tfilt_reg   <= tfilt_next;
            tbyp_reg    <= tbyp_next;
            cop_reg     <= cop_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Duty-cycle sequencer: one on-window per data tick in low power

    sbtc_duty_e  duty_reg, duty_next;
    logic [19:0] ton_reg, ton_next;
    logic [19:0] ton_load;
    logic        on_reg, on_next;

    always_comb begin
        case (avg_reg)
            6'h04:   ton_load = 20'(TON_4X_CYC - 1);
            6'h08:   ton_load = 20'(TON_8X_CYC - 1);
            6'h10:   ton_load = 20'(TON_16X_CYC - 1);
            6'h20:   ton_load = 20'(TON_32X_CYC - 1);
            default: ton_load = 20'(TON_1X_CYC - 1);
        endcase
        duty_next = duty_reg;
        ton_next  = ton_reg;
        if (!low_power_in) begin
            duty_next = SBTC_IDLE;
        end else begin
            case (duty_reg)
                SBTC_IDLE: begin
                    if (odr_tick_in) begin
                        duty_next = SBTC_ON;
                        ton_next  = ton_load;
                    end
                end
                SBTC_ON: begin
                    if (ton_reg == 20'h00000) begin
                        duty_next = SBTC_IDLE;
                    end else begin
                        ton_next = ton_reg - 20'h00001;
                    end
                end
                default: duty_next = SBTC_IDLE;
            endcase
        end
        on_next = !low_power_in || (duty_next == SBTC_ON);
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            duty_reg <= SBTC_IDLE;
            ton_reg  <= 20'h00000;
            on_reg   <= 1'b1;
        end else begin
            duty_reg <= duty_next;
            ton_reg  <= ton_next;
            on_reg   <= on_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame sync: wake, delay measurement and tagging

    logic        clean_sync;
    logic        src_lvl, raw_act;
    logic        act_prev_reg, act_prev_next;
    logic        raw_prev_reg, raw_prev_next;
    logic        wake_reg, wake_next;
    logic        meas_reg, meas_next;
    logic [15:0] dcnt_reg, dcnt_next;
    logic [15:0] dout_reg, dout_next;
    logic        dval_reg, dval_next;
    logic [6:0]  tsel_reg, tsel_next;
    logic        tval_reg, tval_next;

    sbtc_deglitch #(
        .STAGES (`SBTC_DEGLITCH_STAGES)
    ) u_deglitch (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .raw_in     (frame_sync_input_in),
        .clean_out  (clean_sync)
    );

    always_comb begin
        src_lvl = sync_reg[`SBTC_DEGLITCH_BIT] ? clean_sync : frame_sync_input_in;
        act_prev_next = src_lvl ^ sync_polarity_select_in;
        raw_act       = frame_sync_input_in ^ sync_polarity_select_in;
        raw_prev_next = raw_act;
        if (sync_reg[`SBTC_EDGE_SEL_BIT]) begin
            wake_next = act_prev_next & ~act_prev_reg;
        end else begin
            wake_next = act_prev_next;
        end
        meas_next = meas_reg;
        dcnt_next = (dcnt_reg == 16'hffff) ? dcnt_reg : dcnt_reg + 16'h0001;
        dout_next = dout_reg;
        dval_next = 1'b0;
        if (!sync_reg[`SBTC_DELAY_EN_BIT]) begin
            meas_next = 1'b0;
        end else if (raw_act && !raw_prev_reg) begin
            meas_next = 1'b1;
            dcnt_next = 16'h0000;
        end else if (meas_reg && odr_tick_in) begin
            meas_next = 1'b0;
            dout_next = dcnt_reg;
            dval_next = 1'b1;
        end
        tsel_next = 7'h00;
        if (sync_reg[3:0] != 4'h0 && sync_reg[3:0] < 4'h8) begin
            tsel_next = 7'(7'h01 << (sync_reg[2:0] - 3'h1));
        end
        tval_next = tval_reg;
        if (sync_reg[3:0] == 4'h0) begin
            tval_next = 1'b0;
        end else if (odr_tick_in) begin
            tval_next = frame_sync_input_in;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            act_prev_reg <= 1'b0;
            raw_prev_reg <= 1'b0;
            wake_reg     <= 1'b0;
            meas_reg     <= 1'b0;
            dcnt_reg     <= 16'h0000;
            dout_reg     <= 16'h0000;
            dval_reg     <= 1'b0;
            tsel_reg     <= 7'h00;
            tval_reg     <= 1'b0;
        end else begin
            act_prev_reg <= act_prev_next;
            raw_prev_reg <= raw_prev_next;
            wake_reg     <= wake_next;
            meas_reg     <= meas_next;
            dcnt_reg     <= dcnt_next;
            dout_reg     <= dout_next;
            dval_reg     <= dval_next;
            tsel_reg     <= tsel_next;
            tval_reg     <= tval_next;
        end
    end

    assign rdata_out               = rdata_reg;
    assign decim_out               = decim_o_reg;
    assign avg_count_out           = avg_reg;
    assign accel_on_out            = on_reg;
    assign accel_filter_bypass_out = fbyp_reg;
    assign wake_out                = wake_reg;
    assign delay_count_out         = dout_reg;
    assign delay_valid_out         = dval_reg;
    assign tag_select_out          = tsel_reg;
    assign tag_value_out           = tval_reg;
    assign temperature_filter_out  = tfilt_reg;
    assign temp_bypass_out         = tbyp_reg;
    assign coproc_lp_enable_out    = cop_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_decim_wr;
        req_in.wr && bank_in == `SBTC_BANK_USER2 && req_in.addr == `SBTC_ADDR_DECIM;
    endsequence

    sequence s_duty_start;
        low_power_in && duty_reg == SBTC_IDLE && odr_tick_in && avg_reg == 6'h01;
    endsequence

    a_selftest_write: assert property (s_decim_wr |=> ##1
        decim_out.self_x == $past(req_in.wdata[4], 2) &&
        decim_out.self_z == $past(req_in.wdata[2], 2))
        else $error("self-test bits do not follow write");
    a_avg_map: assert property (decim_reg[1:0] == 2'h3 |=> avg_count_out == 6'h20)
        else $error("average 32 not selected");
    a_avg_single: assert property (decim_reg[1:0] == 2'h0 && !accel_filter_choice_in
        |=> avg_count_out == 6'h01)
        else $error("single sample not selected");
    a_duty_window: assert property (s_duty_start |=> accel_on_out &&
        ton_reg == 20'(TON_1X_CYC - 1))
        else $error("duty window not started");
    a_duty_full: assert property (!low_power_in |=> accel_on_out)
        else $error("accel off outside low power");
    a_delay_off: assert property (!sync_reg[7] |=> !delay_valid_out)
        else $error("delay result while disabled");
    a_wake_level: assert property (!sync_reg[4] && !sync_reg[5] &&
        (frame_sync_input_in ^ sync_polarity_select_in) |=> wake_out)
        else $error("level wake missing");
    a_tag_off: assert property (sync_reg[3:0] == 4'h0 |=> tag_select_out == 7'h00 &&
        !tag_value_out)
        else $error("tag active while disabled");
    a_tag_slot: assert property (sync_reg[3:0] == 4'h5 |=> tag_select_out == 7'h10)
        else $error("wrong tag slot");
    a_temp_bypass: assert property (temp_reg[2:0] == 3'h7 |=> temp_bypass_out)
        else $error("temp bypass missing");
    a_reserved_rd: assert property (req_in.rd |=> rdata_out[6] == 1'b0)
        else $error("reserved bit reads one");

endmodule : sbtc_top

/* File: logic/sbtc_regs.svh */
// Register offsets, field positions, reset values and timing figures of the bank-2 block
`ifndef SBTC_REGS_SVH
`define SBTC_REGS_SVH

`define SBTC_BANK_USER2      2'h2
`define SBTC_ADDR_DECIM      7'h15
`define SBTC_ADDR_SYNC       7'h52
`define SBTC_ADDR_TEMP       7'h53
`define SBTC_ADDR_MODCTL     7'h54

`define SBTC_RST_DECIM       8'h00
`define SBTC_RST_SYNC        8'h00
`define SBTC_RST_TEMP        8'h00
`define SBTC_RST_MODCTL      8'h03

`define SBTC_MASK_DECIM      8'h1f
`define SBTC_MASK_SYNC       8'hbf
`define SBTC_MASK_TEMP       8'h07
`define SBTC_MASK_MODCTL     8'h01
`define SBTC_FIXED_MODCTL    8'h02

`define SBTC_ST_X_BIT        4
`define SBTC_ST_Y_BIT        3
`define SBTC_ST_Z_BIT        2
`define SBTC_DELAY_EN_BIT    7
`define SBTC_DEGLITCH_BIT    5
`define SBTC_EDGE_SEL_BIT    4
`define SBTC_LP_COPROC_BIT   0
`define SBTC_TEMP_BYPASS_A   3'h0
`define SBTC_TEMP_BYPASS_B   3'h7
`define SBTC_LPF_AVG4_SET    3'h7

`define SBTC_CLK_PERIOD_NS   10
`define SBTC_TON_1X_US       821
`define SBTC_TON_4X_US       1488
`define SBTC_TON_8X_US       2377
`define SBTC_TON_16X_US      4154
`define SBTC_TON_32X_US      7710
`define SBTC_DEGLITCH_STAGES 3

`endif

/* File: logic/sbtc_pkg.sv */
// Types shared by the bank-2 configuration block
package sbtc_pkg;

    typedef struct packed {
        logic       self_x;
        logic       self_y;
        logic       self_z;
        logic [1:0] avg_sel;
    } sbtc_decim_s;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } sbtc_req_s;

    typedef enum logic {
        SBTC_IDLE,
        SBTC_ON
    } sbtc_duty_e;

endpackage : sbtc_pkg

/* File: logic/sbtc_deglitch.sv */
// Digital filter that passes a level only after it has been stable for STAGES cycles
module sbtc_deglitch #(
    parameter int STAGES = 3
) (
    input  wire logic sys_clk_in, // Core clock
    input  wire logic rst_in,     // Asynchronous reset, high
    input  wire logic raw_in,     // Level to be filtered
    output logic      clean_out   // Filtered level
);

    logic [STAGES-1:0] hist_reg;
    logic [STAGES-1:0] hist_next;
    logic              clean_reg;
    logic              clean_next;

    always_comb begin
        hist_next  = {hist_reg[STAGES-2:0], raw_in};
        clean_next = clean_reg;
        if (&hist_reg) begin
            clean_next = 1'b1;
        end else if (~|hist_reg) begin
            clean_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hist_reg  <= '0;
            clean_reg <= 1'b0;
        end else begin
            hist_reg  <= hist_next;
            clean_reg <= clean_next;
        end
    end

    assign clean_out = clean_reg;

endmodule : sbtc_deglitch

/* File: testbench/sbtc_tb.sv */
// Self-checking bench for the bank-2 configuration block
`include "sbtc_regs.svh"

module testbench
    import sbtc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // Short on-times keep each duty-cycle window to tens of cycles
    localparam int TON1 = 10, TON4 = 20, TON8 = 30, TON16 = 40, TON32 = 50;

    logic        sys_clk_in = 1'b0;
    logic        rst        = 1'b1;
    sbtc_req_s   req        = '0;
    logic [1:0]  bank       = 2'h2;
    logic        fchoice    = 1'b0;
    logic [2:0]  lpset      = 3'h0;
    logic        lp         = 1'b0;
    logic        tick       = 1'b0;
    logic        fs         = 1'b0;
    logic        pol        = 1'b0;
    logic [7:0]  rdata;
    sbtc_decim_s decim;
    logic [5:0]  avg_count;
    logic        accel_on, filt_byp, wake, delay_valid, tag_value, temp_byp, coproc;
    logic [15:0] delay_count;
    logic [6:0]  tag_select;
    logic [2:0]  temp_filt;
    int          err_total  = 0;
    int          num_checks = 0;

    always #5 sys_clk_in = ~sys_clk_in;

    sbtc_top #(.TON_1X_CYC(TON1), .TON_4X_CYC(TON4), .TON_8X_CYC(TON8),
               .TON_16X_CYC(TON16), .TON_32X_CYC(TON32)) dut (
        .sys_clk_in(sys_clk_in), .rst_in(rst), .req_in(req), .bank_in(bank),
        .accel_filter_choice_in(fchoice), .accel_lowpass_setting_in(lpset),
        .low_power_in(lp), .odr_tick_in(tick), .frame_sync_input_in(fs),
        .sync_polarity_select_in(pol), .rdata_out(rdata), .decim_out(decim),
        .avg_count_out(avg_count), .accel_on_out(accel_on),
        .accel_filter_bypass_out(filt_byp), .wake_out(wake),
        .delay_count_out(delay_count), .delay_valid_out(delay_valid),
        .tag_select_out(tag_select), .tag_value_out(tag_value),
        .temperature_filter_out(temp_filt), .temp_bypass_out(temp_byp),
        .coproc_lp_enable_out(coproc));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask : cyc

    // Returns once the written value has reached the outputs
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        cyc(1);
        req.wr = 1'b0;
        cyc(2);
    endtask : wr

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e, input string what);
        req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        cyc(1);
        req.rd = 1'b0;
        cyc(1);
        chk(what, {8'h00, e}, {8'h00, rdata});
    endtask : rd_chk

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset;
        rd_chk(`SBTC_ADDR_DECIM, 8'h00, "decim reset");
        rd_chk(`SBTC_ADDR_SYNC, 8'h00, "sync reset");
        rd_chk(`SBTC_ADDR_TEMP, 8'h00, "temp reset");
        rd_chk(`SBTC_ADDR_MODCTL, 8'h03, "modctl reset");
        chk("coproc reset", 16'h1, {15'h0, coproc});
        $display("test_reset done");
    endtask : test_reset

    task automatic test_bank;
        bank = 2'h0;
        wr(`SBTC_ADDR_DECIM, 8'h1f);
        bank = 2'h2;
        rd_chk(`SBTC_ADDR_DECIM, 8'h00, "other bank write");
        wr(7'h16, 8'hff);
        rd_chk(7'h16, 8'h00, "unmapped read");
        $display("test_bank done");
    endtask : test_bank

    task automatic test_selftest;
        wr(`SBTC_ADDR_DECIM, 8'hff);
        rd_chk(`SBTC_ADDR_DECIM, 8'h1f, "decim mask");
        for (int b = 2; b < 5; b++) begin
            wr(`SBTC_ADDR_DECIM, 8'h01 << b);
            chk("self bits", 16'(1 << (b - 2)),
                {13'h0, decim.self_x, decim.self_y, decim.self_z});
        end
        $display("test_selftest done");
    endtask : test_selftest

    // Each row: filter choice, filter setting, averaging field, samples, on-time
    task automatic test_duty;
        int ch[6]  = '{0, 1, 1, 1, 1, 0};
        int st[6]  = '{3, 7, 7, 7, 7, 2};
        int fld[6] = '{0, 0, 1, 2, 3, 2};
        int avg[6] = '{1, 4, 8, 16, 32, 16};
        int ton[6] = '{TON1, TON4, TON8, TON16, TON32, TON16};
        int n;
        for (int i = 0; i < 6; i++) begin
            fchoice = ch[i][0];
            lpset   = st[i][2:0];
            wr(`SBTC_ADDR_DECIM, 8'(fld[i]));
            cyc(1);
            chk("avg count", 16'(avg[i]), {10'h0, avg_count});
            chk("decim field", 16'(fld[i]), {14'h0, decim.avg_sel});
            chk("filter bypass", 16'(ch[i] == 0), {15'h0, filt_byp});
            lp = 1'b1;
            cyc(2);
            chk("accel idle", 16'h0, {15'h0, accel_on});
            tick = 1'b1;
            cyc(1);
            tick = 1'b0;
            n = 0;
            // A second tick inside the window must not stretch it
            while (accel_on === 1'b1 && n < 200) begin
                n++;
                tick = (n == 4);
                cyc(1);
            end
            tick = 1'b0;
            chk("on time", 16'(ton[i]), n[15:0]);
            lp = 1'b0;
            cyc(2);
            chk("accel full power", 16'h1, {15'h0, accel_on});
        end
        $display("test_duty done");
    endtask : test_duty

    task automatic test_delay;
        int pulses = 0;
        wr(`SBTC_ADDR_SYNC, 8'h80);
        fs = 1'b1;
        cyc(5);
        tick = 1'b1;
        cyc(1);
        tick = 1'b0;
        chk("delay valid", 16'h1, {15'h0, delay_valid});
        chk("delay count", 16'h0004, delay_count);
        cyc(1);
        chk("delay pulse", 16'h0, {15'h0, delay_valid});
        fs = 1'b0;
        wr(`SBTC_ADDR_SYNC, 8'h00);
        fs = 1'b1;
        cyc(3);
        tick = 1'b1;
        repeat (5) begin
            cyc(1);
            tick = 1'b0;
            pulses += (delay_valid === 1'b1);
        end
        chk("measure off", 16'h0, pulses[15:0]);
        fs = 1'b0;
        $display("test_delay done");
    endtask : test_delay

    task automatic test_tag;
        for (int f = 1; f < 9; f++) begin
            wr(`SBTC_ADDR_SYNC, 8'(f % 8));
            chk("tag slot", (f == 8) ? 16'h0 : 16'(1 << (f - 1)), {9'h0, tag_select});
            // Pin low on slot 2 so a stuck-high sample is caught
            fs   = (f != 2);
            tick = 1'b1;
            cyc(1);
            tick = 1'b0;
            fs   = 1'b0;
            cyc(1);
            chk("tag value", 16'(f != 8 && f != 2), {15'h0, tag_value});
        end
        $display("test_tag done");
    endtask : test_tag

    task automatic test_wake;
        int n = 0;
        wr(`SBTC_ADDR_SYNC, 8'h00);
        fs = 1'b1;
        cyc(2);
        chk("level wake", 16'h1, {15'h0, wake});
        fs = 1'b0;
        cyc(2);
        chk("level idle", 16'h0, {15'h0, wake});
        pol = 1'b1;
        cyc(2);
        chk("low active", 16'h1, {15'h0, wake});
        pol = 1'b0;
        wr(`SBTC_ADDR_SYNC, 8'h10);
        fs = 1'b1;
        repeat (6) begin
            cyc(1);
            n += (wake === 1'b1);
        end
        chk("edge pulses", 16'h1, n[15:0]);
        fs = 1'b0;
        wr(`SBTC_ADDR_SYNC, 8'h20);
        n  = 0;
        fs = 1'b1;
        cyc(1);
        fs = 1'b0;
        repeat (8) begin
            cyc(1);
            n += (wake === 1'b1);
        end
        chk("glitch blocked", 16'h0, n[15:0]);
        fs = 1'b1;
        cyc(8);
        chk("steady passes", 16'h1, {15'h0, wake});
        fs = 1'b0;
        cyc(8);
        $display("test_wake done");
    endtask : test_wake

    task automatic test_temp;
        for (int t = 0; t < 8; t++) begin
            wr(`SBTC_ADDR_TEMP, 8'hf8 | 8'(t));
            rd_chk(`SBTC_ADDR_TEMP, 8'(t), "temp field");
            chk("temp select", 16'(t), {13'h0, temp_filt});
            chk("temp bypass", 16'(t == 0 || t == 7), {15'h0, temp_byp});
        end
        $display("test_temp done");
    endtask : test_temp

    task automatic test_modctl;
        wr(`SBTC_ADDR_MODCTL, 8'h00);
        rd_chk(`SBTC_ADDR_MODCTL, 8'h02, "modctl clear");
        chk("coproc off", 16'h0, {15'h0, coproc});
        wr(`SBTC_ADDR_MODCTL, 8'hfd);
        rd_chk(`SBTC_ADDR_MODCTL, 8'h03, "modctl set");
        chk("coproc on", 16'h1, {15'h0, coproc});
        wr(`SBTC_ADDR_MODCTL, 8'h00);
        wr(`SBTC_ADDR_SYNC, 8'hff);
        rd_chk(`SBTC_ADDR_SYNC, 8'hbf, "sync mask");
        // Second reset in mid-run must restore every register
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        cyc(1);
        test_reset();
        $display("test_modctl done");
    endtask : test_modctl

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("Checks made %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (20000) @(posedge sys_clk_in);
        err_total++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        wrap_up();
    end

    initial begin
        repeat (6) @(negedge sys_clk_in);
        rst = 1'b0;
        cyc(1);
        test_reset();
        test_bank();
        test_selftest();
        test_duty();
        test_delay();
        test_tag();
        test_wake();
        test_temp();
        test_modctl();
        wrap_up();
    end

endmodule : testbench
